/* dv/pci_io_read_cfg_write_master_test.sv */
// pci_io_read_cfg_write_master_test: random and directed host transfers
// assumes pim_master and pim_target_model; pull-ups on frame and irdy
`timescale 1ns/1ns
module pci_io_read_cfg_write_master_test;
    logic clk, rst_n, hostReqValid, hostReqReady, hostRspValid, hostIrq, reqN, gntN;
    logic clrMasterAbort, clrTargetAbort, enMasterAbortIrq, enTargetAbortIrq;
    logic frameNOut, frameOe, irdyNOut, irdyOe, adOe, cbeOe, devselN, trdyN, stopN;
    logic [31:0] hostRspData, statusBits, adOut, targetAd, rdata, seenAddr, seenData;
    logic [31:0] rnd, lastRd;
    logic [15:0] ioAddrUpper;
    logic [3:0] cbeNOut, seenCmd, seenBe;
    logic [7:0] base, phases;
    logic [1:0] mode;
    pim_pkg::pim_req_type hostReq;
    int err_count, checked;
    wire frameW = frameOe ? frameNOut : 1'b1;
    wire irdyW = irdyOe ? irdyNOut : 1'b1;
    wire [31:0] adW = adOe ? adOut : targetAd;
    pim_master pim_master_inst (.clk(clk), .rst_n(rst_n), .hostReqValid(hostReqValid),
        .hostReqReady(hostReqReady), .hostReq(hostReq), .ioAddrUpper(ioAddrUpper),
        .hostRspValid(hostRspValid), .hostRspData(hostRspData), .clrMasterAbort(clrMasterAbort),
        .clrTargetAbort(clrTargetAbort), .enMasterAbortIrq(enMasterAbortIrq),
        .enTargetAbortIrq(enTargetAbortIrq), .statusBits(statusBits), .hostIrq(hostIrq),
        .reqN(reqN), .gntN(gntN), .frameNIn(frameW), .frameNOut(frameNOut), .frameOe(frameOe),
        .irdyNIn(irdyW), .irdyNOut(irdyNOut), .irdyOe(irdyOe), .adIn(adW), .adOut(adOut),
        .adOe(adOe), .cbeNOut(cbeNOut), .cbeOe(cbeOe), .devselN(devselN), .trdyN(trdyN),
        .stopN(stopN));
    pim_target_model pim_target_model_inst (.clk(clk), .reqN(reqN), .frameW(frameW),
        .adW(adW), .cbeNOut(cbeNOut), .mode(mode), .rdata(rdata), .base(base), .gntN(gntN),
        .devselN(devselN), .trdyN(trdyN), .stopN(stopN), .targetAd(targetAd),
        .phases(phases), .seenAddr(seenAddr), .seenCmd(seenCmd), .seenBe(seenBe),
        .seenData(seenData));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] expAddr(input logic cfg, input logic t1, input logic [31:0] a);
        logic [20:0] sel;
        sel = (a[15:11] <= 5'h14) ? (21'h1 << a[15:11]) : 21'h0;
        if (!cfg) begin
            return {ioAddrUpper, a[15:0]};
        end
        if (a[23:22] == pim_pkg::DECODE_REGION && !t1) begin
            return {sel, a[10:2], pim_pkg::LOW_TYPE0};
        end
        return {8'h0, a[23:2], t1 ? pim_pkg::LOW_TYPE1 : pim_pkg::LOW_TYPE0};
    endfunction
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic cfg, input logic t1, input logic [31:0] a,
            input logic [3:0] m, input logic [1:0] md);
        int n;
        logic [31:0] expRd;
        rnd = lfsr(rnd);
        rdata = rnd;
        rnd = lfsr(rnd);
        hostReq = {cfg, t1, a, m, rnd};
        {mode, base, enMasterAbortIrq, enTargetAbortIrq} = {md, phases, rdata[1:0]};
        hostReqValid = 1'b1;
        @(negedge clk);
        hostReqValid = 1'b0;
        n = 0;
        while (hostRspValid !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk32(n < 300, 1'b1);
        expRd = md >= 2'h2 ? pim_pkg::ALL_ONES : rdata;
        chk32(hostRspData, cfg ? lastRd : expRd);
        if (!cfg) begin
            lastRd = expRd;
        end
        @(negedge clk);
        chk32(seenAddr, expAddr(cfg, t1, a));
        chk32({28'h0, seenCmd}, cfg ? pim_pkg::CMD_CFG_WRITE : pim_pkg::CMD_IO_READ);
        chk32(8'(phases - base), md == 2'h1 ? 8'h3 : 8'h1);
        if (md < 2'h2) begin
            chk32({28'h0, seenBe}, {28'h0, ~m});
            // a read data phase must carry the target's word, so the master left ad released
            chk32(seenData, cfg ? hostReq.wdata : rdata);
        end
        chk32(statusBits, {2'h0, md == 2'h3, md == 2'h2, 28'h0});
        chk32(hostIrq, (md == 2'h3 && rdata[1]) || (md == 2'h2 && rdata[0]));
        {clrMasterAbort, clrTargetAbort} = 2'h3;
        @(negedge clk);
        {clrMasterAbort, clrTargetAbort} = 2'h0;
        @(negedge clk);
        chk32(statusBits, 32'h0);
        chk32(hostIrq, 1'b0);
    endtask
    task close_out;
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        err_count++;
        close_out;
    end
    initial begin
        {rst_n, hostReqValid, hostReq, ioAddrUpper, mode, rdata, base} = '0;
        {clrMasterAbort, clrTargetAbort, enMasterAbortIrq, enTargetAbortIrq} = 4'h0;
        {rnd, lastRd, err_count, checked} = {32'h000115b4, 32'h0, 32'h0, 32'h0};
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk32({statusBits[30:0], reqN}, 32'h1);
        // every select code, each outcome in turn, in the decode region
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            run(1'b1, 1'b0, {rnd[31:24], 2'h3, rnd[21:16], i[4:0], rnd[10:0]},
                rnd[3:0], i[1:0]);
        end
        // type 0 config writes as software forms them: one device select bit in 23:11
        for (int i = 0; i < 13; i++) begin
            rnd = lfsr(rnd);
            run(1'b1, 1'b0, {rnd[31:24], 13'h0001 << i, rnd[10:0]},
                rnd[3:0], rnd[9:8]);
        end
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            ioAddrUpper = rnd[31:16];
            run(rnd[0], rnd[1], rnd, rnd[7:4], rnd[9:8]);
        end
        close_out;
    end
endmodule

/* dv/pim_target_model.sv */
// pim_target_model: behavioural pci target and arbiter that grants one cycle after a request
// assumes resolved frame and ad wires; target lines have pull-ups
`timescale 1ns/1ns
module pim_target_model (
    input wire logic clk,
    input wire logic reqN,
    input wire logic frameW,
    input wire logic [31:0] adW,
    input wire logic [3:0] cbeNOut,
    input wire logic [1:0] mode,
    input wire logic [31:0] rdata,
    input wire logic [7:0] base,
    output logic gntN,
    output logic devselN,
    output logic trdyN,
    output logic stopN,
    output logic [31:0] targetAd,
    output logic [7:0] phases,
    output logic [31:0] seenAddr,
    output logic [3:0] seenCmd,
    output logic [3:0] seenBe,
    output logic [31:0] seenData
);
    logic frameQ = 1'b1;
    logic addrPhase;
    logic retryNow;
    logic okNow;
    // mode 0 claims, 1 retries the first two tries, 2 target abort, 3 nobody claims
    assign addrPhase = !frameW && frameQ;
    assign retryNow = mode == 2'h1 && (phases - base) < 8'h2;
    assign okNow = mode == 2'h0 || (mode == 2'h1 && !retryNow);
    initial begin
        {gntN, devselN, trdyN, stopN} = 4'hf;
        {targetAd, phases} = 40'h0;
    end
    always @(posedge clk) begin
        frameQ <= frameW;
        gntN <= reqN;
        {devselN, trdyN, stopN} <= 3'h7;
        // released ad lines never hold the last value
        targetAd <= ~targetAd;
        if (!trdyN) begin
            seenBe <= cbeNOut;
            seenData <= adW;
        end
        if (addrPhase) begin
            phases <= phases + 8'h1;
            seenAddr <= adW;
            seenCmd <= cbeNOut;
            devselN <= !(okNow || retryNow);
            trdyN <= !okNow;
            stopN <= !(retryNow || mode == 2'h2);
            if (okNow) begin
                targetAd <= rdata;
            end
        end
    end
endmodule

/* hdl/pim_cfg_addr.sv */
// pim_cfg_addr: configuration address former, direct or one-hot select decode
// assumes a stable host address; purely combinational
`timescale 1ns/1ns
module pim_cfg_addr (
    input wire logic [31:0] hostAddr,
    input wire logic cfgType1,
    output logic decodeMode,
    output logic [31:0] cfgAddr
);
    logic [4:0] sel;
    logic [20:0] selBits;
    logic [31:0] directAddr;
    logic [31:0] decodedAddr;

    assign sel = hostAddr[15:11];
    assign decodeMode = (hostAddr[23:22] == pim_pkg::DECODE_REGION) && !cfgType1;

    // codes above the top select fall out of the compare as all zeros
    genvar i;
    generate
        for (i = 0; i <= pim_pkg::DECODE_SEL_MAX; i++) begin : g_sel
            assign selBits[i] = (sel == 5'(i));
        end
    endgenerate

    assign directAddr = {8'h00, hostAddr[23:2],
                         cfgType1 ? pim_pkg::LOW_TYPE1 : pim_pkg::LOW_TYPE0};
    assign decodedAddr = {selBits, hostAddr[10:2], pim_pkg::LOW_TYPE0};
    assign cfgAddr = decodeMode ? decodedAddr : directAddr;
endmodule

/* hdl/pim_master.sv */
// pim_master: single-dword pci i/o read and configuration write master
// assumes pci signals synchronous to clk and an external wired bus resolver
`timescale 1ns/1ns
module pim_master (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hostReqValid,
    output logic hostReqReady,
    input wire pim_pkg::pim_req_type hostReq,
    input wire logic [15:0] ioAddrUpper,
    output logic hostRspValid,
    output logic [31:0] hostRspData,
    input wire logic clrMasterAbort,
    input wire logic clrTargetAbort,
    input wire logic enMasterAbortIrq,
    input wire logic enTargetAbortIrq,
    output logic [31:0] statusBits,
    output logic hostIrq,
    output logic reqN,
    input wire logic gntN,
    input wire logic frameNIn,
    output logic frameNOut,
    output logic frameOe,
    input wire logic irdyNIn,
    output logic irdyNOut,
    output logic irdyOe,
    input wire logic [31:0] adIn,
    output logic [31:0] adOut,
    output logic adOe,
    output logic [3:0] cbeNOut,
    output logic cbeOe,
    input wire logic devselN,
    input wire logic trdyN,
    input wire logic stopN
);
    pim_pkg::pim_state_type state_ff, nxt_state;
    pim_pkg::pim_req_type req_ff;
    logic [2:0] wait_ff;
    logic [1:0] backoff_ff;
    logic mAbort_ff, tAbort_ff;
    logic rspValid_ff;
    logic [31:0] rspData_ff;
    logic decodeMode;
    logic [31:0] cfgAddr;
    logic [31:0] pciAddr;
    logic inData, okEv, retryEv, tAbortEv, mAbortEv, doneEv, busIdle;

    pim_cfg_addr u_cfg_addr (
        .hostAddr(req_ff.addr),
        .cfgType1(req_ff.cfgType1),
        .decodeMode(decodeMode),
        .cfgAddr(cfgAddr)
    );

    assign pciAddr = req_ff.isCfg ? cfgAddr : {ioAddrUpper, req_ff.addr[15:0]};
    assign busIdle = frameNIn && irdyNIn;
    assign inData = (state_ff == pim_pkg::ST_DATA);
    assign okEv = inData && !devselN && !trdyN;
    assign retryEv = inData && !devselN && trdyN && !stopN;
    // stop without devsel can only follow a claim, so it is the abort case
    assign tAbortEv = inData && devselN && !stopN;
    assign mAbortEv = inData && devselN && stopN && (wait_ff == pim_pkg::DEVSEL_LIMIT - 3'h1);
    assign doneEv = okEv || tAbortEv || mAbortEv;

    // only a single data phase is ever issued, so frame drops with the address
    assign hostReqReady = (state_ff == pim_pkg::ST_IDLE);
    assign reqN = !(state_ff == pim_pkg::ST_REQ);
    assign frameOe = (state_ff == pim_pkg::ST_ADDR) || inData || (state_ff == pim_pkg::ST_TURN);
    assign frameNOut = !(state_ff == pim_pkg::ST_ADDR);
    assign irdyOe = frameOe;
    assign irdyNOut = !inData;
    assign cbeOe = (state_ff == pim_pkg::ST_ADDR) || inData;
    assign cbeNOut = (state_ff == pim_pkg::ST_ADDR) ?
                     (req_ff.isCfg ? pim_pkg::CMD_CFG_WRITE : pim_pkg::CMD_IO_READ)
                     : ~req_ff.byteMask;
    assign adOe = (state_ff == pim_pkg::ST_ADDR) || (inData && req_ff.isCfg);
    assign adOut = (state_ff == pim_pkg::ST_ADDR) ? pciAddr : req_ff.wdata;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pim_pkg::ST_IDLE: begin
                if (hostReqValid) nxt_state = pim_pkg::ST_REQ;
            end
            pim_pkg::ST_REQ: begin
                if (!gntN && busIdle) nxt_state = pim_pkg::ST_ADDR;
            end
            pim_pkg::ST_ADDR: nxt_state = pim_pkg::ST_DATA;
            pim_pkg::ST_DATA: begin
                if (retryEv) nxt_state = pim_pkg::ST_BACKOFF;
                else if (doneEv) nxt_state = pim_pkg::ST_TURN;
            end
            pim_pkg::ST_TURN: nxt_state = pim_pkg::ST_IDLE;
            pim_pkg::ST_BACKOFF: begin
                if (backoff_ff == pim_pkg::RETRY_BACKOFF - 2'h1) begin
                    nxt_state = pim_pkg::ST_REQ;
                end
            end
            default: nxt_state = pim_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= pim_pkg::ST_IDLE;
            req_ff <= '0;
            wait_ff <= 3'h0;
            backoff_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            // request held unchanged so a retry repeats exactly the same command
            if (hostReqValid && hostReqReady) req_ff <= hostReq;
            wait_ff <= inData ? wait_ff + 3'h1 : 3'h0;
            backoff_ff <= (state_ff == pim_pkg::ST_BACKOFF) ? backoff_ff + 2'h1 : 2'h0;
        end
    end

    // write data of an aborted config write is simply never retried
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rspValid_ff <= 1'b0;
            rspData_ff <= pim_pkg::RESET_WORD;
        end else begin
            rspValid_ff <= doneEv;
            if (okEv && !req_ff.isCfg) begin
                rspData_ff <= adIn;
            end else if ((mAbortEv || tAbortEv) && !req_ff.isCfg) begin
                rspData_ff <= pim_pkg::ALL_ONES;
            end
        end
    end
    assign hostRspValid = rspValid_ff;
    assign hostRspData = rspData_ff;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mAbort_ff <= 1'b0;
            tAbort_ff <= 1'b0;
        end else begin
            mAbort_ff <= mAbortEv || (mAbort_ff && !clrMasterAbort);
            tAbort_ff <= tAbortEv || (tAbort_ff && !clrTargetAbort);
        end
    end

    always_comb begin
        statusBits = '0;
        statusBits[pim_pkg::BIT_RCVD_MABORT] = mAbort_ff;
        statusBits[pim_pkg::BIT_RCVD_TABORT] = tAbort_ff;
    end
    assign hostIrq = (mAbort_ff && enMasterAbortIrq)
                     || (tAbort_ff && enTargetAbortIrq);

    io_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_ADDR && !req_ff.isCfg) |-> cbeNOut == pim_pkg::CMD_IO_READ
        ##1 (inData && cbeNOut == ~req_ff.byteMask && !adOe))
        else $error("io read command or byte enables wrong");
    cfg_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_ADDR && req_ff.isCfg) |-> cbeNOut == pim_pkg::CMD_CFG_WRITE
        ##1 (adOe && adOut == req_ff.wdata && cbeNOut == ~req_ff.byteMask))
        else $error("config write phase wrong");
    retry_repeat_a: assert property (@(posedge clk) disable iff (!rst_n)
        retryEv |=> (state_ff == pim_pkg::ST_BACKOFF && reqN)[*2] ##1 (!reqN && $stable(req_ff)))
        else $error("retry did not re-request same command");
    mabort_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mAbortEv && !req_ff.isCfg) |=> hostRspValid && hostRspData == pim_pkg::ALL_ONES
        && statusBits[29])
        else $error("master abort read result wrong");
    tabort_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tAbortEv && !req_ff.isCfg) |=> hostRspValid && hostRspData == pim_pkg::ALL_ONES
        && statusBits[28])
        else $error("target abort read result wrong");
    mabort_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_ADDR ##1 (inData && devselN && stopN)[*5]) |-> mAbortEv
        ##1 statusBits[29])
        else $error("master abort not taken after five cycles");
    abort_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        ((mAbortEv || tAbortEv) && req_ff.isCfg) |=> !adOe ##1 (hostReqReady && !adOe))
        else $error("aborted config write not dropped");
    direct_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_ADDR && req_ff.isCfg && !decodeMode) |->
        adOut[31:24] == 8'h00 && adOut[23:2] == req_ff.addr[23:2]
        && adOut[1:0] == {1'b0, req_ff.cfgType1})
        else $error("direct config address wrong");
    decode_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_ADDR && req_ff.isCfg && decodeMode
        && req_ff.addr[15:11] > 5'h14) |-> adOut[31:11] == 21'h000000)
        else $error("high select code not zero");
    decode_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_ADDR && req_ff.isCfg && decodeMode
        && req_ff.addr[15:11] <= 5'h14) |-> adOut[31:11] == (21'h000001 << req_ff.addr[15:11])
        && adOut[10:2] == req_ff.addr[10:2] && adOut[1:0] == 2'h0)
        else $error("decoded select address wrong");
    // the bus is left idle after one data phase so the next owner sees a clean turnaround
    data_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
        inData |-> frameOe && frameNOut && irdyOe && !irdyNOut && cbeOe)
        else $error("single data phase signalling wrong");
    turn_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == pim_pkg::ST_TURN) |-> frameOe && frameNOut && irdyOe && irdyNOut && !adOe
        ##1 (!frameOe && !irdyOe && !cbeOe && hostReqReady))
        else $error("bus not released after the transfer");
    cfg_mabort_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mAbortEv && req_ff.isCfg) |=> hostRspValid && statusBits[29] && $stable(hostRspData))
        else $error("config write master abort handling wrong");
    cfg_tabort_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tAbortEv && req_ff.isCfg) |=> hostRspValid && statusBits[28] && $stable(hostRspData))
        else $error("config write target abort handling wrong");
endmodule

/* include/pim_pkg.sv */
// pim_pkg: constants and carriers for the pci io-read / config-write master
// assumes one 100 mhz clock shared by the host side and the pci side
package pim_pkg;
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
    localparam int BIT_RCVD_MABORT = 29;
    localparam int BIT_RCVD_TABORT = 28;
    localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
    localparam logic [1:0] RETRY_BACKOFF = 2'h2;
    localparam logic [31:0] ALL_ONES = 32'hffffffff;
    localparam logic [1:0] LOW_TYPE0 = 2'h0;
    localparam logic [1:0] LOW_TYPE1 = 2'h1;
    localparam logic [1:0] DECODE_REGION = 2'h3;
    localparam int DECODE_SEL_MAX = 20;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN, ST_BACKOFF
    } pim_state_type;

    // isCfg=1: configuration write, isCfg=0: i/o read
    typedef struct packed {
        logic isCfg;
        logic cfgType1;
        logic [31:0] addr;
        logic [3:0] byteMask;
        logic [31:0] wdata;
    } pim_req_type;
endpackage
